// ==== inc/pin_state_pkg.sv ====
// Package for the pin state controller: modes, bus structs, timing.
// Assumes a 20 MHz system clock and a single async active-low reset.
package pin_state_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int POWERUP_US = 1000;
    localparam int POWERUP_CYCLES = (CLK_HZ / 1000000) * POWERUP_US;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int AD_W = 16;
    localparam int AU_W = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [AD_W-1:0] AD_RESET = 16'h0000;
    localparam logic [AU_W-1:0] AU_RESET = 6'h00;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_HALT,
        MODE_IDLE,
        MODE_STOP,
        MODE_BUS_IDLE,
        MODE_HOLD
    } power_mode_e;

    // Levels the bus controller would drive in normal operation
    typedef struct packed {
        logic [AD_W-1:0] ad;
        logic [AD_W-1:0] addr_lo;
        logic [AU_W-1:0] addr_hi;
        logic wr_lo;
        logic wr_hi;
        logic rd;
        logic address_latch_strobe;
        logic grant_ack;
        logic ad_drive;
    } bus_out_s;

    // Output enables, active low
    typedef struct packed {
        logic ad_oe_n;
        logic addr_oe_n;
        logic strobe_oe_n;
        logic grant_ack_oe_n;
    } bus_oe_s;

endpackage

// ==== rtl/pin_state_standby_control.sv ====
// Pin state controller for reset, power-up, standby, bus idle and hold.
// Assumes all inputs are synchronous to clk_i; power-on reset releases
// resetn_i, external/internal reset causes arrive as sync levels.
//
// Overview of operation
// (R01) During reset every external bus control pin is an undriven input.
// (R02) Debug reset input is pulled low on pin reset, follows the debug mode bit on internal reset.
// (R03) Idle levels apply in the bus idle state after T2 (separate) or T3 (multiplexed).
// (R04) In HALT, address, strobes and grant ack keep operating while DMA runs.
// (R05) In HALT the muxed bus floats in separate mode and is undefined in multiplexed mode.
// (R06) A held pin keeps the level of the last external bus cycle before the mode.
// (R07) Inputs marked not acknowledged, such as wait, are not sampled.
// (R08) A pin whose alternate function runs keeps running it in HALT, IDLE and STOP.
// (R09) Debug serial out floats in reset unless on-chip debug mode is selected.
// (R10) The power-on state lasts until 1 ms after supply is good, debug reset pulled down.
// (R11) IDLE and STOP drive clock out low and strobes high; HALT and bus idle keep it running.
// (R12) In bus hold the bus floats, grant ack is low and the grant request is still watched.
`timescale 1ns/1ps
module pin_state_standby_control #(
    parameter int POWERUP_CYCLES = pin_state_pkg::POWERUP_CYCLES,
    parameter int PORT_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic pin_reset_i,
    input wire logic internal_reset_i,
    input wire logic debug_mode_select_bit_i,
    input wire pin_state_pkg::power_mode_e mode_i,
    input wire logic separate_bus_i,
    input wire logic dma_active_i,
    input wire logic bus_cycle_end_i,
    input wire pin_state_pkg::bus_out_s bus_i,
    input wire logic sys_clk_level_i,
    input wire logic wait_pin_i,
    input wire logic bus_grant_request_i,
    input wire logic [PORT_W-1:0] port_alt_active_i,
    input wire logic [PORT_W-1:0] port_live_i,
    input wire logic [PORT_W-1:0] port_dir_out_i,
    input wire logic debug_serial_out_i,
    input wire logic [1:0] analog_output_port_i,
    output pin_state_pkg::bus_out_s bus_o,
    output pin_state_pkg::bus_oe_s oe_o,
    output logic system_clock_output_o,
    output logic wait_sampled_o,
    output logic bus_grant_request_seen_o,
    output logic [PORT_W-1:0] port_o,
    output logic [PORT_W-1:0] port_oe_n_o,
    output logic debug_reset_pulldown_o,
    output logic debug_serial_out_o,
    output logic debug_serial_out_oe_n_o,
    output logic [1:0] analog_output_port_o,
    output logic analog_valid_o,
    output logic powerup_done_o
);
    pin_state_pkg::bus_out_s held;
    pin_state_pkg::bus_out_s next_bus;
    pin_state_pkg::bus_oe_s next_oe;
    logic [PORT_W-1:0] port_held;
    logic [1:0] analog_held;
    logic in_reset;
    logic pin_reset_seen;
    logic powerup_done;

    // ------------------------------------------------------------
    // Power-up interval
    // ------------------------------------------------------------
    powerup_timer #(.CYCLES(POWERUP_CYCLES)) u_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .done_o(powerup_done)
    );
    assign powerup_done_o = powerup_done;

    assign in_reset = !powerup_done || pin_reset_i || internal_reset_i;

    // Last reset cause; pin reset wins when both arrive together
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_reset_seen <= 1'b1;
        end else if (pin_reset_i) begin
            pin_reset_seen <= 1'b1;
        end else if (internal_reset_i) begin
            pin_reset_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Held levels of the last bus cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            held <= '{ad: pin_state_pkg::AD_RESET, addr_lo: pin_state_pkg::AD_RESET,
                      addr_hi: pin_state_pkg::AU_RESET, wr_lo: 1'b1, wr_hi: 1'b1,
                      rd: 1'b1, address_latch_strobe: 1'b1, grant_ack: 1'b1, ad_drive: 1'b0};
        end else if (mode_i == pin_state_pkg::MODE_RUN && bus_cycle_end_i) begin
            held <= bus_i; // [R06]
        end
    end

    // Ports and analog outputs freeze on leaving run mode
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_held <= '0;
            analog_held <= 2'h0;
        end else if (mode_i == pin_state_pkg::MODE_RUN) begin
            port_held <= port_live_i;
            analog_held <= analog_output_port_i;
        end
    end

    // ------------------------------------------------------------
    // Bus pin selection
    // ------------------------------------------------------------
    always_comb begin
        next_bus = bus_i;
        next_oe = '{ad_oe_n: !bus_i.ad_drive, addr_oe_n: 1'b0, strobe_oe_n: 1'b0,
                    grant_ack_oe_n: 1'b0};
        case (mode_i)
            pin_state_pkg::MODE_RUN: begin
            end
            pin_state_pkg::MODE_HALT: begin
                if (!dma_active_i) begin
                    next_bus = held; // [R04]
                    next_bus.wr_lo = 1'b1;
                    next_bus.wr_hi = 1'b1;
                    next_bus.rd = 1'b1;
                    next_bus.address_latch_strobe = 1'b1;
                    next_oe.ad_oe_n = separate_bus_i ? 1'b1 : held.ad_drive; // [R05]
                end
            end
            pin_state_pkg::MODE_IDLE, pin_state_pkg::MODE_STOP: begin
                next_bus = held;
                next_bus.wr_lo = 1'b1; // [R11]
                next_bus.wr_hi = 1'b1;
                next_bus.rd = 1'b1;
                next_bus.address_latch_strobe = 1'b1;
                next_oe.ad_oe_n = 1'b1;
            end
            pin_state_pkg::MODE_BUS_IDLE: begin
                // Entered after T2 separate or T3 multiplexed [R03]
                next_bus = held; // [R06]
                next_bus.wr_lo = 1'b1;
                next_bus.wr_hi = 1'b1;
                next_bus.rd = 1'b1;
                next_bus.address_latch_strobe = 1'b1;
                next_oe.ad_oe_n = !held.ad_drive;
            end
            pin_state_pkg::MODE_HOLD: begin
                next_bus = held;
                next_bus.grant_ack = 1'b0; // [R12]
                next_oe = '{ad_oe_n: 1'b1, addr_oe_n: 1'b1, strobe_oe_n: 1'b1,
                            grant_ack_oe_n: 1'b0};
            end
            default: begin
                next_oe = '1;
            end
        endcase
        if (in_reset) begin
            next_oe = '1; // [R01]
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_o <= '0;
            oe_o <= '1;
        end else begin
            bus_o <= next_bus;
            oe_o <= next_oe;
        end
    end

    // Clock out is combinational: it must track the system clock level
    assign system_clock_output_o = !in_reset && sys_clk_level_i &&
        !(mode_i == pin_state_pkg::MODE_IDLE || mode_i == pin_state_pkg::MODE_STOP); // [R11]

    // ------------------------------------------------------------
    // Inputs not acknowledged
    // ------------------------------------------------------------
    assign wait_sampled_o = !in_reset && (mode_i == pin_state_pkg::MODE_RUN ||
        (mode_i == pin_state_pkg::MODE_HALT && dma_active_i)) && wait_pin_i; // [R07]
    assign bus_grant_request_seen_o = !in_reset && (mode_i == pin_state_pkg::MODE_RUN ||
        mode_i == pin_state_pkg::MODE_HOLD || mode_i == pin_state_pkg::MODE_HALT)
        && bus_grant_request_i; // [R12]

    // ------------------------------------------------------------
    // Ordinary ports
    // ------------------------------------------------------------
    for (genvar i = 0; i < PORT_W; i++) begin : g_port
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                port_o[i] <= 1'b0;
                port_oe_n_o[i] <= 1'b1;
            end else if (in_reset) begin
                port_o[i] <= 1'b0;
                port_oe_n_o[i] <= 1'b1;
            end else if (mode_i == pin_state_pkg::MODE_RUN || port_alt_active_i[i]) begin
                port_o[i] <= port_live_i[i]; // [R08]
                port_oe_n_o[i] <= !port_dir_out_i[i];
            end else begin
                port_o[i] <= port_held[i]; // [R06]
                port_oe_n_o[i] <= !port_dir_out_i[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Debug and analog pins
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            debug_reset_pulldown_o <= 1'b1;
            debug_serial_out_o <= 1'b0;
            debug_serial_out_oe_n_o <= 1'b1;
            analog_output_port_o <= 2'h0;
            analog_valid_o <= 1'b0;
        end else begin
            if (!powerup_done || pin_reset_i) begin
                debug_reset_pulldown_o <= 1'b1; // [R10] [R02]
            end else if (internal_reset_i || !pin_reset_seen) begin
                debug_reset_pulldown_o <= !debug_mode_select_bit_i; // [R02]
            end
            debug_serial_out_o <= debug_serial_out_i;
            debug_serial_out_oe_n_o <= in_reset && !debug_mode_select_bit_i; // [R09]
            analog_valid_o <= powerup_done && !in_reset &&
                mode_i != pin_state_pkg::MODE_STOP; // [R10]
            analog_output_port_o <= (mode_i == pin_state_pkg::MODE_RUN) ?
                analog_output_port_i : analog_held;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        in_reset |=> oe_o == '1) else $error("bus driven in reset"); // [R01]
    pin_pulldown_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pin_reset_i |=> debug_reset_pulldown_o) else $error("no pulldown"); // [R02]
    internal_rst_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        internal_reset_i && !pin_reset_i && powerup_done
        |=> debug_reset_pulldown_o == !$past(debug_mode_select_bit_i))
        else $error("debug reset wrong"); // [R02]
    idle_strobes_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !in_reset && mode_i == pin_state_pkg::MODE_BUS_IDLE
        |=> bus_o.rd && bus_o.address_latch_strobe && bus_o.addr_lo == $past(held.addr_lo))
        else $error("idle levels"); // [R03]
    halt_dma_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !in_reset && mode_i == pin_state_pkg::MODE_HALT && dma_active_i
        |=> bus_o.address_latch_strobe == $past(bus_i.address_latch_strobe)) else $error("halt dma"); // [R04]
    halt_sep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mode_i == pin_state_pkg::MODE_HALT && !dma_active_i && separate_bus_i
        |=> oe_o.ad_oe_n) else $error("halt ad driven"); // [R05]
    wait_ignored_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mode_i inside {pin_state_pkg::MODE_IDLE, pin_state_pkg::MODE_STOP,
        pin_state_pkg::MODE_BUS_IDLE} |-> !wait_sampled_o) else $error("wait sampled"); // [R07]
    alt_live_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !in_reset && port_alt_active_i[0] |=> port_o[0] == $past(port_live_i[0]))
        else $error("alt port frozen"); // [R08]
    ddo_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        in_reset && !debug_mode_select_bit_i |=> debug_serial_out_oe_n_o)
        else $error("ddo driven"); // [R09]
    powerup_len_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(powerup_done) |-> $past(oe_o.ad_oe_n) && debug_reset_pulldown_o)
        else $error("powerup state"); // [R10]
    stop_clock_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mode_i == pin_state_pkg::MODE_STOP |-> !system_clock_output_o
        ##1 (in_reset || bus_o.wr_lo)) else $error("stop clock"); // [R11]
    hold_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !in_reset && mode_i == pin_state_pkg::MODE_HOLD
        |=> !bus_o.grant_ack && oe_o.addr_oe_n && oe_o.strobe_oe_n)
        else $error("hold pins"); // [R12]
    halt_dma_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mode_i == pin_state_pkg::MODE_HALT && dma_active_i);
    hold_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mode_i == pin_state_pkg::MODE_HOLD && bus_grant_request_i);
    int_reset_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        internal_reset_i && debug_mode_select_bit_i);
endmodule

// ==== rtl/powerup_timer.sv ====
// Power-on hold timer: flags when the startup interval has elapsed.
// Assumes the clock runs from power-up and reset clears the count.
`timescale 1ns/1ps
module powerup_timer #(
    parameter int CYCLES = pin_state_pkg::POWERUP_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    output logic done_o
);
    logic [$clog2(CYCLES+1)-1:0] count;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= '0;
        end else if (count != CYCLES[$clog2(CYCLES+1)-1:0]) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (count == CYCLES[$clog2(CYCLES+1)-1:0] - 1'b1) | done_o;
        end
    end
endmodule

// ==== tb/ext_bus_master.sv ====
// Far-side model: external master asking for the bus, and the wait source.
// Assumes the bench steers the wish to own the bus; changes land on negedge.
`timescale 1ns/1ps
module ext_bus_master (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic want_i,
    input wire logic grant_ack_i,
    output logic bus_grant_request_o,
    output logic wait_o
);
    // Request kept up while the grant is still high, as a real master would
    always @(negedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_grant_request_o <= 1'b0;
            wait_o <= 1'b0;
        end else begin
            bus_grant_request_o <= want_i | (bus_grant_request_o & grant_ack_i);
            // Toggles every cycle so an unsampled input cannot match by luck
            wait_o <= ~wait_o;
        end
    end
endmodule

// ==== tb/test_pin_state_standby_control.sv ====
// Bench for the pin state controller: reset, power-up and standby mode levels.
// Assumes the design package is compiled first and the partner model beside it.
`timescale 1ns/1ps
module test_pin_state_standby_control;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic pin_rst = 1'b0;
    logic int_rst = 1'b0;
    logic dbg = 1'b0;
    pin_state_pkg::power_mode_e mode_i = pin_state_pkg::MODE_RUN;
    logic sep_i = 1'b0;
    logic dma_i = 1'b0;
    logic end_i = 1'b0;
    pin_state_pkg::bus_out_s bus_i = '0;
    logic sys_clk = 1'b0;
    logic want = 1'b0;
    logic ddo_in = 1'b0;
    logic [1:0] ana_in = 2'h0;
    logic [7:0] alt = 8'h00, live = 8'h00, dir = 8'h00;
    pin_state_pkg::bus_out_s bus_o;
    pin_state_pkg::bus_oe_s oe_o;
    logic clk_out, wait_seen, req_seen, pd, ddo_oe_n, done, wait_pin, grant_req;
    logic [7:0] port_o, port_oe_n;
    logic ddo_out, ana_ok;
    logic [1:0] ana_out;
    integer seed = 32'hA4BC8956;
    int err_count = 0;
    int tests_run = 0;
    int held_lo, held_hi, held_port, held_ana;
    logic [63:0] rnd;

    always #25 clk_i = ~clk_i;

    pin_state_standby_control #(.POWERUP_CYCLES(10), .PORT_W(8)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .pin_reset_i(pin_rst),
        .internal_reset_i(int_rst), .debug_mode_select_bit_i(dbg), .mode_i(mode_i),
        .separate_bus_i(sep_i), .dma_active_i(dma_i), .bus_cycle_end_i(end_i),
        .bus_i(bus_i), .sys_clk_level_i(sys_clk), .wait_pin_i(wait_pin),
        .bus_grant_request_i(grant_req), .port_alt_active_i(alt), .port_live_i(live),
        .port_dir_out_i(dir), .debug_serial_out_i(ddo_in), .analog_output_port_i(ana_in),
        .bus_o(bus_o), .oe_o(oe_o), .system_clock_output_o(clk_out),
        .wait_sampled_o(wait_seen), .bus_grant_request_seen_o(req_seen), .port_o(port_o),
        .port_oe_n_o(port_oe_n), .debug_reset_pulldown_o(pd), .debug_serial_out_o(ddo_out),
        .debug_serial_out_oe_n_o(ddo_oe_n), .analog_output_port_o(ana_out),
        .analog_valid_o(ana_ok), .powerup_done_o(done));

    ext_bus_master partner (.clk_i(clk_i), .resetn_i(resetn_i), .want_i(want),
        .grant_ack_i(bus_o.grant_ack),
        .bus_grant_request_o(grant_req), .wait_o(wait_pin));

    // ------------------------------------------------------------
    // Compare and close
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Reset scenarios
    // ------------------------------------------------------------
    task automatic por_check();
        int n;
        @(negedge clk_i);
        resetn_i = 1'b0;
        dbg = 1'b0;
        mode_i = pin_state_pkg::MODE_RUN;
        repeat (20) @(negedge clk_i);
        chk(oe_o, 4'hF);
        chk(port_oe_n, 8'hFF);
        chk(pd, 1'b1);
        chk(ddo_oe_n, 1'b1);
        chk(ana_ok, 1'b0);
        resetn_i = 1'b1;
        repeat (5) @(negedge clk_i);
        chk(done, 1'b0);
        chk(oe_o, 4'hF);
        n = 0;
        while (done !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        chk(n, 5);
        $display("test power-on finished");
    endtask

    task automatic rst_src(input logic p, input logic i, input logic d);
        pin_rst = p;
        int_rst = i;
        dbg = d;
        repeat (3) @(negedge clk_i);
        chk(oe_o, 4'hF);
        chk(pd, 1'(p | ~d));
        chk(ddo_oe_n, 1'(~d));
        pin_rst = 1'b0;
        int_rst = 1'b0;
        repeat (15) @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // One mode cycle: drive at negedge, check at the next
    // ------------------------------------------------------------
    task automatic step(input pin_state_pkg::power_mode_e m, input logic dma, input logic sep);
        logic run;
        logic [7:0] exp_port;
        run = (m == pin_state_pkg::MODE_RUN);
        rnd = {$random(seed), $random(seed)};
        mode_i = m;
        dma_i = dma;
        sep_i = sep;
        bus_i = rnd[43:0];
        end_i = run | rnd[44];
        sys_clk = rnd[45];
        {ddo_in, ana_in} = rnd[48:46];
        {alt, live, dir, want} = 25'($random(seed));
        exp_port = (alt & live) | (~alt & 8'(held_port));
        if (run) begin
            held_lo = bus_i.addr_lo;
            held_hi = bus_i.addr_hi;
            held_port = live;
            held_ana = ana_in;
        end
        @(negedge clk_i);
        chk(clk_out, sys_clk & !(m inside {pin_state_pkg::MODE_IDLE,
            pin_state_pkg::MODE_STOP}));
        case (m)
            pin_state_pkg::MODE_RUN: begin
                chk(wait_seen, wait_pin);
            end
            pin_state_pkg::MODE_HALT: begin
                if (dma) begin
                    chk(bus_o.addr_lo, bus_i.addr_lo);
                    chk(bus_o.grant_ack, bus_i.grant_ack);
                    chk(wait_seen, wait_pin);
                end else begin
                    chk(bus_o.addr_lo, held_lo);
                    chk({bus_o.wr_lo, bus_o.wr_hi, bus_o.rd, bus_o.address_latch_strobe}, 4'hF);
                    if (sep) begin
                        chk(oe_o.ad_oe_n, 1'b1);
                    end
                end
            end
            pin_state_pkg::MODE_BUS_IDLE: begin
                chk({bus_o.wr_lo, bus_o.wr_hi, bus_o.rd, bus_o.address_latch_strobe}, 4'hF);
                chk({bus_o.addr_hi, bus_o.addr_lo}, {held_hi[5:0], held_lo[15:0]});
            end
            pin_state_pkg::MODE_HOLD: begin
                chk(bus_o.grant_ack, 1'b0);
                chk({oe_o.ad_oe_n, oe_o.addr_oe_n, oe_o.strobe_oe_n}, 3'h7);
                chk(req_seen, grant_req);
            end
            default: begin
                chk({bus_o.wr_lo, bus_o.wr_hi, bus_o.rd, bus_o.address_latch_strobe}, 4'hF);
                chk(oe_o.ad_oe_n, 1'b1);
            end
        endcase
        if (m inside {pin_state_pkg::MODE_HALT, pin_state_pkg::MODE_IDLE,
            pin_state_pkg::MODE_STOP}) begin
            chk(port_o, exp_port);
        end
        chk(port_oe_n, 8'(~dir));
        chk(ddo_out, ddo_in);
        chk(ana_out, run ? ana_in : 2'(held_ana));
        chk(ana_ok, m != pin_state_pkg::MODE_STOP);
        if (!run && !(m == pin_state_pkg::MODE_HALT && dma)) begin
            chk(wait_seen, 1'b0);
        end
        if (m inside {pin_state_pkg::MODE_IDLE, pin_state_pkg::MODE_STOP,
            pin_state_pkg::MODE_BUS_IDLE}) begin
            chk(req_seen, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        por_check();
        rst_src(1'b1, 1'b0, 1'b1);
        rst_src(1'b0, 1'b1, 1'b1);
        rst_src(1'b0, 1'b1, 1'b0);
        rst_src(1'b1, 1'b1, 1'b1);
        $display("test reset sources finished");
        for (int i = 0; i < 48; i++) begin
            step(pin_state_pkg::MODE_RUN, 1'b0, 1'b0);
            step(pin_state_pkg::power_mode_e'(3'(i % 6)), 1'((i / 6) % 2), 1'((i / 12) % 2));
        end
        $display("test mode table finished");
        // Random modes back to back, run included; standby steps other than HALT with DMA keep the bus levels of the last run cycle
        for (int i = 0; i < 100; i++) begin
            step(pin_state_pkg::power_mode_e'(3'($unsigned($random(seed)) % 6)),
                1'($random(seed)), 1'($random(seed)));
        end
        $display("test random modes finished");
        por_check();
        results();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #(50 * 5000);
        err_count++;
        results();
    end
endmodule
